/* File: sts_pkg.sv */
// Package for the SPI target unit with memory channels and semaphore
package sts_pkg;
  localparam int ADDR_W = 32;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] RX_LIMIT_MAX = 10'h3ff;
  localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;

  // Who holds the semaphore
  typedef enum logic [1:0] {
    STS_SEM_OFF = 2'b00,
    STS_SEM_CPU = 2'b01,
    STS_SEM_FREE = 2'b10,
    STS_SEM_SPI = 2'b11
  } sts_sem_e;

  // Configuration from the CPU side
  typedef struct packed {
    logic enable;
    logic cpol;
    logic cpha;
    logic end_to_request;
    logic [7:0] ignored_fill_char;
    logic [7:0] tx_excess_flag_fill_char;
    logic [CNT_W-1:0] rx_limit;
    logic [CNT_W-1:0] tx_limit;
    logic [ADDR_W-1:0] rx_buffer_pointer;
    logic [ADDR_W-1:0] tx_buffer_pointer;
  } sts_cfg_s;

  // Status of the last granted transaction
  typedef struct packed {
    logic rx_excess_flag;
    logic tx_excess_flag;
    logic [CNT_W-1:0] rx_count_last;
    logic [CNT_W-1:0] tx_count_last;
  } sts_stat_s;
endpackage

/* File: sts_spi_target.sv */
// SPI target with memory channels and semaphore arbitration
`default_nettype none
module sts_spi_target (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire sts_pkg::sts_cfg_s cfg_i,
  input wire logic request_task_i,
  input wire logic release_task_i,
  output logic granted_event_o,
  output logic done_event_o,
  output logic rx_buffer_full_event_o,
  output logic cpu_owns_o,
  output sts_pkg::sts_stat_s stat_o,
  output logic mem_rd_req_o,
  output logic [sts_pkg::ADDR_W-1:0] mem_rd_addr_o,
  input wire logic mem_rd_ack_i,
  input wire logic [7:0] mem_rd_data_i,
  output logic mem_wr_req_o,
  output logic [sts_pkg::ADDR_W-1:0] mem_wr_addr_o,
  output logic [7:0] mem_wr_data_o,
  input wire logic mem_wr_ack_i,
  input wire logic sck_i,
  input wire logic chip_select_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o
);
  localparam int CW = sts_pkg::CNT_W;

  // Chip select synchronised into the system clock domain
  logic cs_s1_ff, cs_s2_ff, cs_s3_ff;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_s3_ff <= 1'b1;
    end else begin
      cs_s1_ff <= chip_select_n_i;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
    end
  end
  logic cs_fall, cs_rise;
  assign cs_fall = cs_s3_ff && !cs_s2_ff;
  assign cs_rise = !cs_s3_ff && cs_s2_ff;

  // Semaphore arbiter
  sts_pkg::sts_sem_e sem_ff, nxt_sem;
  logic pend_ff, nxt_pend, grant_ff, nxt_grant, granted_ff, nxt_granted;
  logic done_ff, nxt_done;
  always_comb begin
    nxt_sem = sem_ff;
    nxt_pend = pend_ff;
    nxt_grant = 1'b0;
    nxt_done = 1'b0;
    nxt_granted = granted_ff;
    if (!cfg_i.enable) begin
      nxt_sem = sts_pkg::STS_SEM_OFF;
      nxt_pend = 1'b0;
      nxt_granted = 1'b0;
    end else begin
      unique case (sem_ff)
        sts_pkg::STS_SEM_OFF: nxt_sem = sts_pkg::STS_SEM_CPU;
        sts_pkg::STS_SEM_CPU: begin
          if (request_task_i) nxt_grant = 1'b1;
          else if (release_task_i) nxt_sem = sts_pkg::STS_SEM_FREE;
          if (cs_fall) nxt_granted = 1'b0;
        end
        sts_pkg::STS_SEM_FREE: begin
          if (request_task_i) begin
            nxt_sem = sts_pkg::STS_SEM_CPU;
            nxt_grant = 1'b1;
          end else if (cs_fall) begin
            nxt_sem = sts_pkg::STS_SEM_SPI;
            nxt_granted = 1'b1;
          end
        end
        sts_pkg::STS_SEM_SPI: begin
          if (request_task_i) nxt_pend = 1'b1;
          if (cs_rise) begin
            nxt_done = 1'b1;
            nxt_granted = 1'b0;
            // One grant whether pending, shortcut or both
            if (pend_ff || request_task_i || cfg_i.end_to_request) begin
              nxt_sem = sts_pkg::STS_SEM_CPU;
              nxt_grant = 1'b1;
            end else begin
              nxt_sem = sts_pkg::STS_SEM_FREE;
            end
            nxt_pend = 1'b0;
          end
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sem_ff <= sts_pkg::STS_SEM_OFF;
      pend_ff <= 1'b0;
      grant_ff <= 1'b0;
      done_ff <= 1'b0;
      granted_ff <= 1'b0;
    end else begin
      sem_ff <= nxt_sem;
      pend_ff <= nxt_pend;
      grant_ff <= nxt_grant;
      done_ff <= nxt_done;
      granted_ff <= nxt_granted;
    end
  end
  assign granted_event_o = grant_ff;
  assign done_event_o = done_ff;
  assign cpu_owns_o = (sem_ff == sts_pkg::STS_SEM_CPU);
  // Pointers and RAM stay reachable by the CPU at all times

  // Transmit prefetch buffer: system fills, link consumes via toggles
  logic [7:0] txb_ff;
  logic txb_valid_ff, tx_take_tgl_ff, tk_s1_ff, tk_s2_ff, tk_s3_ff;
  logic [CW-1:0] tx_fetch_ff, rx_wr_ff;
  logic rd_busy_ff, tx_hit_ff;
  // Fetch one byte ahead while granted and below tx_limit whenever the buffer is empty
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      txb_ff <= sts_pkg::BYTE_RST;
      txb_valid_ff <= 1'b0;
      tx_fetch_ff <= sts_pkg::CNT_RST;
      rd_busy_ff <= 1'b0;
      tk_s1_ff <= 1'b0;
      tk_s2_ff <= 1'b0;
      tk_s3_ff <= 1'b0;
      tx_hit_ff <= 1'b0;
    end else begin
      tk_s1_ff <= tx_take_tgl_ff;
      tk_s2_ff <= tk_s1_ff;
      tk_s3_ff <= tk_s2_ff;
      if (nxt_granted && !granted_ff) begin
        tx_fetch_ff <= sts_pkg::CNT_RST;
        txb_valid_ff <= 1'b0;
        tx_hit_ff <= 1'b0;
      end else if (tk_s3_ff != tk_s2_ff) begin
        if (txb_valid_ff) tx_fetch_ff <= tx_fetch_ff + 1'b1;
        else if (granted_ff) tx_hit_ff <= 1'b1;
        txb_valid_ff <= 1'b0;
      end else if (rd_busy_ff && mem_rd_ack_i) begin
        txb_ff <= mem_rd_data_i;
        txb_valid_ff <= 1'b1;
      end
      if (mem_rd_ack_i) rd_busy_ff <= 1'b0;
      else if (granted_ff && !txb_valid_ff && !rd_busy_ff &&
               tx_fetch_ff < cfg_i.tx_limit) rd_busy_ff <= 1'b1;
    end
  end
  assign mem_rd_req_o = rd_busy_ff;
  assign mem_rd_addr_o = cfg_i.tx_buffer_pointer +
    {{(sts_pkg::ADDR_W-CW){1'b0}}, tx_fetch_ff};

  // Shift engine on the link clock, mode chosen by cpha and cpol
  logic [2:0] bit_ff;
  logic [7:0] rx_sh_ff, tx_sh_ff, rx_hold_ff;
  logic rx_tgl_ff;
  logic sample_clk;
  assign sample_clk = sck_i ^ cfg_i.cpol ^ cfg_i.cpha;
  always_ff @(posedge sample_clk or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      bit_ff <= 3'h0;
      rx_sh_ff <= sts_pkg::BYTE_RST;
    end else begin
      rx_sh_ff <= {rx_sh_ff[6:0], mosi_i};
      bit_ff <= bit_ff + 3'h1;
    end
  end
  // Completed byte handed to the system domain with a toggle
  always_ff @(posedge sample_clk or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_hold_ff <= sts_pkg::BYTE_RST;
      rx_tgl_ff <= 1'b0;
    end else if (!chip_select_n_i && bit_ff == sts_pkg::BIT_LAST) begin
      rx_hold_ff <= {rx_sh_ff[6:0], mosi_i};
      rx_tgl_ff <= ~rx_tgl_ff;
    end
  end
  // Output shifter on the launch edge, loaded per byte.
  // Grant settles a few system cycles after select falls and holds past
  // the select rise, so the link reads it as a quasi-static level; a sync
  // clocked by the link clock would go stale while the clock stands still.
  logic [7:0] next_tx;
  assign next_tx = !granted_ff ? cfg_i.ignored_fill_char :
    (txb_valid_ff ? txb_ff : cfg_i.tx_excess_flag_fill_char);
  logic [2:0] obit_ff;
  always_ff @(negedge sample_clk or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      obit_ff <= 3'h0;
      tx_sh_ff <= sts_pkg::BYTE_RST;
    end else begin
      obit_ff <= obit_ff + 3'h1;
      // Leading-edge sampling already showed bit 7 straight from next_tx
      if (obit_ff != 3'h0) tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
      else if (cfg_i.cpha) tx_sh_ff <= next_tx;
      else tx_sh_ff <= {next_tx[6:0], 1'b0};
    end
  end
  always_ff @(negedge sample_clk or negedge nrst_i) begin
    if (!nrst_i) tx_take_tgl_ff <= 1'b0;
    else if (!chip_select_n_i && obit_ff == 3'h0)
      tx_take_tgl_ff <= ~tx_take_tgl_ff;
  end
  logic cpha_first;
  assign cpha_first = !cfg_i.cpha && obit_ff == 3'h0;
  // First bit driven straight from select when sampling leads
  assign miso_o = cpha_first ? next_tx[7] : tx_sh_ff[7];
  assign miso_oe_o = !chip_select_n_i;

  // Receive channel in the system domain
  logic rt_s1_ff, rt_s2_ff, rt_s3_ff, wr_busy_ff, rx_full_ff, rx_hit_ff;
  logic [7:0] wr_data_ff;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rt_s1_ff <= 1'b0;
      rt_s2_ff <= 1'b0;
      rt_s3_ff <= 1'b0;
      wr_busy_ff <= 1'b0;
      wr_data_ff <= sts_pkg::BYTE_RST;
      rx_wr_ff <= sts_pkg::CNT_RST;
      rx_full_ff <= 1'b0;
      rx_hit_ff <= 1'b0;
    end else begin
      rt_s1_ff <= rx_tgl_ff;
      rt_s2_ff <= rt_s1_ff;
      rt_s3_ff <= rt_s2_ff;
      rx_full_ff <= 1'b0;
      // Acknowledge frees the channel; a new byte arriving with it keeps it busy
      if (mem_wr_ack_i) wr_busy_ff <= 1'b0;
      if (nxt_granted && !granted_ff) begin
        rx_wr_ff <= sts_pkg::CNT_RST;
        rx_hit_ff <= 1'b0;
      end else if (rt_s3_ff != rt_s2_ff && granted_ff) begin
        if (rx_wr_ff < cfg_i.rx_limit &&
            (!wr_busy_ff || mem_wr_ack_i)) begin
          wr_busy_ff <= 1'b1;
          wr_data_ff <= rx_hold_ff;
          rx_wr_ff <= rx_wr_ff + 1'b1;
          rx_full_ff <= (rx_wr_ff + 1'b1) == cfg_i.rx_limit;
        end else begin
          rx_hit_ff <= 1'b1;
        end
      end
    end
  end
  assign mem_wr_req_o = wr_busy_ff;
  assign mem_wr_data_o = wr_data_ff;
  assign mem_wr_addr_o = cfg_i.rx_buffer_pointer +
    {{(sts_pkg::ADDR_W-CW){1'b0}}, rx_wr_ff - 1'b1};
  assign rx_buffer_full_event_o = rx_full_ff;

  // Status latched at the end of each granted transaction
  sts_pkg::sts_stat_s stat_ff;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_ff <= '0;
    end else if (nxt_done) begin
      stat_ff.rx_excess_flag <= rx_hit_ff;
      stat_ff.tx_excess_flag <= tx_hit_ff;
      stat_ff.rx_count_last <= rx_wr_ff;
      stat_ff.tx_count_last <= tx_fetch_ff;
    end
  end
  assign stat_o = stat_ff;
endmodule // sts_spi_target
`default_nettype wire

/* File: sts_spi_target_properties.sv */
// Concurrent checks on the ports of the SPI target unit
`default_nettype none
module sts_spi_target_properties (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire sts_pkg::sts_cfg_s cfg_i,
  input wire logic request_task_i,
  input wire logic release_task_i,
  input wire logic granted_event_o,
  input wire logic done_event_o,
  input wire logic rx_buffer_full_event_o,
  input wire logic cpu_owns_o,
  input wire sts_pkg::sts_stat_s stat_o,
  input wire logic mem_rd_req_o,
  input wire logic [sts_pkg::ADDR_W-1:0] mem_rd_addr_o,
  input wire logic mem_wr_req_o,
  input wire logic [sts_pkg::ADDR_W-1:0] mem_wr_addr_o,
  input wire logic mem_wr_ack_i,
  input wire logic chip_select_n_i,
  input wire logic miso_oe_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // Output released while deselected
  a_miso_released: assert property (chip_select_n_i |-> !miso_oe_o)
    else $error("miso driven while deselected");
  a_grant_owner: assert property (granted_event_o |-> cpu_owns_o)
    else $error("grant without ownership");
  a_cpu_regrant: assert property (request_task_i && cpu_owns_o |->
    ##[1:2] granted_event_o)
    else $error("no grant for owner request");
  a_release_frees: assert property (release_task_i && !request_task_i &&
    cpu_owns_o |-> ##[1:2] !cpu_owns_o)
    else $error("release kept ownership");
  a_cpu_kept: assert property (cfg_i.enable && cpu_owns_o && !release_task_i &&
    !$past(release_task_i) |=> cpu_owns_o)
    else $error("ownership taken from cpu");
  a_done_cs_high: assert property (done_event_o |-> chip_select_n_i)
    else $error("done while selected");
  a_shortcut_cpu: assert property (done_event_o && cfg_i.end_to_request
    |-> ##[0:2] cpu_owns_o)
    else $error("shortcut did not hand over");
  a_stat_at_done: assert property (!done_event_o && !$past(done_event_o)
    |-> $stable(stat_o))
    else $error("status changed outside done");
  a_rx_window: assert property (mem_wr_req_o |-> (mem_wr_addr_o -
    cfg_i.rx_buffer_pointer) < 32'(cfg_i.rx_limit))
    else $error("write beyond receive limit");
  a_tx_window: assert property (mem_rd_req_o |-> (mem_rd_addr_o -
    cfg_i.tx_buffer_pointer) < 32'(cfg_i.tx_limit))
    else $error("read beyond transmit limit");
  a_wr_held: assert property (mem_wr_req_o && !mem_wr_ack_i |=>
    mem_wr_req_o && $stable(mem_wr_addr_o))
    else $error("write request dropped early");
  c_ignored: cover property ($fell(chip_select_n_i) && cpu_owns_o);
  c_shortcut: cover property (done_event_o && cfg_i.end_to_request);
  c_full: cover property (rx_buffer_full_event_o);
endmodule // sts_spi_target_properties
bind sts_spi_target sts_spi_target_properties sts_spi_target_properties_inst (.*);
`default_nettype wire

/* File: sts_spi_master_model.sv */
// Behavioural SPI master driving frames into the target
`default_nettype none
module sts_spi_master_model (
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic miso_i,
  output logic sck_o,
  output logic chip_select_n_o,
  output logic mosi_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] txb [4];
  logic [7:0] rxb [4];
  // Idle state, clock stands still at its polarity between frames
  initial begin
    chip_select_n_o = 1'b1;
    mosi_o = 1'b0;
    sck_o = 1'b0;
  end
  always @(cpol_i) if (chip_select_n_o) sck_o = cpol_i;
  // One frame of n whole bytes, 6 ns clock, select held throughout
  task automatic frame(input int n);
    chip_select_n_o = 1'b0;
    #100;
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        if (!cpha_i) mosi_o = txb[k][i];
        #3 sck_o = ~sck_o;
        if (cpha_i) mosi_o = txb[k][i];
        else rxb[k][i] = miso_i;
        #3 sck_o = ~sck_o;
        if (cpha_i) rxb[k][i] = miso_i;
      end
    end
    #20 chip_select_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #100;
  endtask
endmodule // sts_spi_master_model
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the SPI target unit
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i, nrst_i, req, rel, rack, wack, sck, cs_n, mosi;
  logic miso, moe, miso_w, mrd, mwr, gnt, done, full, owns;
  logic [7:0] rdat, wdat;
  logic [31:0] radr, wadr;
  sts_pkg::sts_cfg_s cfg;
  sts_pkg::sts_stat_s stat;
  logic [7:0] mem [256];
  int errors, num_checks, n_gnt, n_done, n_full, n_wr, g;
  // Released line shows a changing pattern
  assign miso_w = moe ? miso : ref_clk_i;
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  sts_spi_target sts_spi_target_inst (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .cfg_i(cfg), .request_task_i(req),
    .release_task_i(rel), .granted_event_o(gnt), .done_event_o(done),
    .rx_buffer_full_event_o(full), .cpu_owns_o(owns), .stat_o(stat),
    .mem_rd_req_o(mrd), .mem_rd_addr_o(radr), .mem_rd_ack_i(rack),
    .mem_rd_data_i(rdat), .mem_wr_req_o(mwr), .mem_wr_addr_o(wadr),
    .mem_wr_data_o(wdat), .mem_wr_ack_i(wack), .sck_i(sck),
    .chip_select_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
    .miso_oe_o(moe));
  sts_spi_master_model sts_spi_master_model_inst (.cpol_i(cfg.cpol),
    .cpha_i(cfg.cpha), .miso_i(miso_w), .sck_o(sck),
    .chip_select_n_o(cs_n), .mosi_o(mosi));
  // Memory answers one cycle after each request; events are counted
  always @(posedge ref_clk_i) begin
    rack <= #1 mrd & ~rack;
    wack <= #1 mwr & ~wack;
    rdat <= #1 mem[radr[7:0]];
    if (wack) mem[wadr[7:0]] <= wdat;
    n_wr <= n_wr + int'(wack);
    n_gnt <= n_gnt + int'(gnt);
    n_done <= n_done + int'(done);
    n_full <= n_full + int'(full);
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One-cycle request (r=1) or release (r=0) pulse
  task automatic pulse(input logic r);
    tick();
    req = r;
    rel = ~r;
    tick();
    req = 1'b0;
    rel = 1'b0;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    nrst_i = 1'b0;
    {req, rel, rack, wack} = 4'h0;
    cfg = '0;
    cfg.enable = 1'b1;
    cfg.ignored_fill_char = 8'ha5;
    cfg.tx_excess_flag_fill_char = 8'h5a;
    cfg.rx_limit = 10'h003;
    cfg.tx_limit = 10'h002;
    cfg.rx_buffer_pointer = 32'h0000_0080;
    cfg.tx_buffer_pointer = 32'h0000_0010;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i);
    tick(4);
    nrst_i = 1'b1;
    tick(3);
    chk(owns, 1);
    chk(n_gnt, 0);
    pulse(1);
    tick(2);
    chk(n_gnt, 1);
    sts_spi_master_model_inst.frame(2);
    chk(sts_spi_master_model_inst.rxb[1], 8'ha5);
    chk(n_wr + n_done, 0);
    pulse(0);
    pulse(0);
    chk(owns, 0);
    for (int m = 0; m < 4; m++) begin
      {cfg.cpol, cfg.cpha} = 2'(m);
      tick(2);
      for (int k = 0; k < 4; k++) begin
        sts_spi_master_model_inst.txb[k] = 8'(8'hc0 + m * 4 + k);
      end
      sts_spi_master_model_inst.frame(4);
      for (int k = 0; k < 4; k++) begin
        chk(sts_spi_master_model_inst.rxb[k], k < 2 ? 8'(16 + k) : 8'h5a);
        chk(mem[8'h80 + k], 8'(k < 3 ? 8'hc0 + m * 4 + k : 8'h83));
      end
      chk(stat, {2'b11, 10'h003, 10'h002});
      chk(n_full, m + 1);
      chk(n_done, m + 1);
      chk(owns, 0);
    end
    cfg.end_to_request = 1'b1;
    g = n_gnt;
    fork
      sts_spi_master_model_inst.frame(2);
      begin
        #150;
        pulse(1);
        chk(owns, 0);
      end
    join
    chk(n_gnt - g, 1);
    pulse(0);
    sts_spi_master_model_inst.frame(1);
    chk(owns, 1);
    // Disable and enable again: CPU owns with no granted event
    g = n_gnt;
    cfg.enable = 1'b0;
    tick(2);
    chk(owns, 0);
    cfg.enable = 1'b1;
    tick(3);
    chk(owns, 1);
    chk(n_gnt - g, 0);
    finish_test();
  end
  // Watchdog for a hung run
  initial begin
    #20000;
    errors++;
    finish_test();
  end
endmodule // testbench
`default_nettype wire
